// File: serial_flash_full_cycle_port_tb.sv
// self-checking bench for the serial flash port
`timescale 1ns/1ps
module serial_flash_full_cycle_port_tb;
   import sffcp_pkg::*;
   localparam int EP = 20;
   localparam int OT = 10;
   localparam int XF = 10;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cs_n, sck, mosi, miso, oe_n, busy;
   logic [7:0] mem [64];
   int n_fail = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   // identification values arbitrary
   sffcp_dev #(.EP_CYC(EP), .OTPP_CYC(OT), .XFR_CYC(XF), .MFR_ID(8'h3c), .DEV_ID(16'ha5c3))
      i_dut (.clk(clk), .rstn(rstn), .cs_n_pin(cs_n), .sck_pin(sck), .mosi_pin(mosi),
      .miso_q(miso), .miso_oe_n_q(oe_n), .busy_q(busy));
   sffcp_host i_host (.clk(clk), .cs_n_pin(cs_n), .sck_pin(sck), .mosi_pin(mosi),
      .miso_q(miso), .miso_oe_n_q(oe_n));
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] op, input int pg, input int ix, input logic m3);
      logic [23:0] a;
      a = 24'(pg * 16 + ix);
      i_host.sel(m3);
      i_host.xb(op);
      for (int k = 2; k >= 0; k--)
         i_host.xb(a[k*8 +: 8]);
   endtask : cmd
   task automatic tbusy(input int n);
      int c;
      int w;
      c = 0;
      w = 0;
      while (busy !== 1'b1 && w < 8)
      begin
         @(posedge clk);
         w++;
      end
      while (busy === 1'b1 && c < 100000)
      begin
         @(posedge clk);
         c++;
      end
      chk("busy cycles", n, c);
   endtask : tbusy
   task automatic rd(input logic [7:0] op, input int pg, input int ix, input int n);
      int e;
      cmd(op, pg, ix, 1'b0);
      repeat (DUMMY_BYTES) i_host.xb(IDLE_BYTE);
      for (int i = 0; i < n; i++)
      begin
         i_host.xb(IDLE_BYTE);
         e = (op == OP_PAGE_READ) ? pg * 16 + (ix + i) % 16 : (pg * 16 + ix + i) % 64;
         chk("read byte", mem[e], i_host.rx);
      end
      i_host.desel;
   endtask : rd
   task automatic pr(input logic [7:0] op, input int pg, input int n, input logic m3);
      logic [7:0] d;
      cmd(op, pg, 0, m3);
      for (int i = 0; i < n; i++)
      begin
         d = 8'(pg * 37 + i * 5 + 1);
         mem[pg * 16 + i] = d;
         i_host.xb(d);
      end
      i_host.desel;
      tbusy(EP);
   endtask : pr
   task automatic t_id;
      logic [7:0] exp [4];
      exp = '{8'h3c, 8'ha5, 8'hc3, 8'h00};
      for (int m = 0; m < 2; m++)
      begin
         i_host.sel(m[0]);
         i_host.xb(OP_ID_READ);
         for (int i = 0; i < 4; i++)
         begin
            i_host.xb(IDLE_BYTE);
            chk("id byte", exp[i], i_host.rx);
         end
         i_host.desel;
      end
   endtask : t_id
   task automatic t_prog;
      pr(OP_PROG_BUF1, 1, 16, 1'b0);
      pr(OP_PROG_BUF2, 2, 16, 1'b1);
      rd(OP_PAGE_READ, 1, 3, 17);
      rd(OP_ARRAY_READ, 1, 14, 4);
   endtask : t_prog
   task automatic t_copy;
      for (int b = 0; b < 2; b++)
      begin
         cmd(b ? OP_XFER_BUF2 : OP_XFER_BUF1, 2 - b, 0, b[0]);
         i_host.desel;
         tbusy(XF);
         pr(b ? OP_PROG_BUF2 : OP_PROG_BUF1, 3 * (1 - b), 0, b[0]);
         for (int i = 0; i < 16; i++)
            mem[48 - 48 * b + i] = mem[32 - 16 * b + i];
         rd(OP_PAGE_READ, 3 * (1 - b), 0, 16);
      end
   endtask : t_copy
   task automatic t_otp;
      i_host.sel(1'b0);
      i_host.xb(OP_OTP_PROG);
      for (int i = 0; i < 4; i++)
         i_host.xb(8'(i + 8'h40));
      i_host.desel;
      tbusy(OT);
      i_host.sel(1'b0);
      i_host.xb(OP_STATUS_READ);
      for (int i = 0; i < 2; i++)
      begin
         i_host.xb(IDLE_BYTE);
         chk("status byte", {1'b1, STATUS_LOW}, i_host.rx);
      end
      i_host.desel;
   endtask : t_otp
   task automatic t_refresh;
      int ptr;
      ptr = 0;
      for (int p = 0; p < 4; p++)
      begin
         cmd(OP_XFER_BUF1, ptr, 0, 1'b0);
         i_host.desel;
         tbusy(XF);
         pr(OP_PROG_BUF1, ptr, 0, 1'b0);
         rd(OP_PAGE_READ, ptr, 5, 16);
         ptr = (ptr + 1) % 4;
      end
   endtask : t_refresh
   task automatic t_abort;
      i_host.sel(1'b0);
      i_host.xb(OP_PROG_BUF1);
      i_host.xb(8'h00);
      i_host.desel;
      repeat (12) @(posedge clk);
      chk("busy after abort", 1'b0, busy);
      rd(OP_PAGE_READ, 0, 0, 16);
   endtask : t_abort
   task automatic test_done;
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_id;
      t_prog;
      t_copy;
      t_refresh;
      t_otp;
      t_abort;
      test_done;
   end
   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("unexpected run time: expected done, seen hang");
      test_done;
   end
endmodule : serial_flash_full_cycle_port_tb

// File: sffcp_dev.sv
// serial flash slave: full-cycle shifting, reads, buffers, timed programs
// Notes on behaviour
// RULE_01: output bits change on sck falling edges, input bits sampled on rising edges.
// RULE_02: host captures each output bit on the following falling edge.
// RULE_03: host launches input bits on rising edges, device samples next rising edge.
// RULE_04: sck low at select is mode 0, sck high is mode 3; both work.
// RULE_05: in spi-compatible timing, output is valid within the sck low phase.
// RULE_06: general full-cycle timing, host samples one period after launch, to 85MHz.
// RULE_07: buffer page erase and program keeps the device busy up to 25 ms.
// RULE_08: security area program keeps the device busy up to 500 us.
// RULE_09: opcode d2h streams bytes from the addressed page, wrapping within it.
// RULE_10: opcode e8h streams bytes sequentially through the whole array.
// RULE_11: opcode 9fh returns manufacturer then device identification bytes.
// RULE_12: page to buffer copy fills the buffer chosen by the opcode.
// RULE_13: host writes pages directly or through a buffer then program.
// RULE_14: host rewrites every sector page within 50,000 program operations.
// RULE_15: host keeps a pointer naming the next page to rewrite.
// RULE_16: low-power host may refresh all pages after 50,000 operations.
// RULE_17: page to buffer copy completes within 200 us, busy meanwhile.
// RULE_18: bytes travel msb first; select rising early aborts the command.
// RULE_19: host waits for busy to clear before another timed operation.
`timescale 1ns/1ps
module sffcp_dev
   import sffcp_pkg::*;
#(
   parameter int PAGES = 4,
   parameter int PAGE_BYTES = 16,
   parameter int OTP_BYTES = 16,
   parameter int EP_CYC = T_EP_CYC,
   parameter int OTPP_CYC = T_OTPP_CYC,
   parameter int XFR_CYC = T_XFR_CYC,
   parameter logic [7:0] MFR_ID = 8'h5a,    // arbitrary value
   parameter logic [15:0] DEV_ID = 16'h1234  // arbitrary value
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic mosi_pin,
   output logic miso_q,
   output logic miso_oe_n_q,
   output logic busy_q
);
   localparam int BW = $clog2(PAGE_BYTES);
   localparam int AW = $clog2(PAGES * PAGE_BYTES);
   localparam int OW = $clog2(OTP_BYTES);
   if ((PAGE_BYTES & (PAGE_BYTES - 1)) != 0 || (PAGES & (PAGES - 1)) != 0 || PAGES < 2
      || (OTP_BYTES & (OTP_BYTES - 1)) != 0 || OTP_BYTES > PAGE_BYTES || PAGE_BYTES < 2
      || EP_CYC < 2 || OTPP_CYC < 2 || XFR_CYC < 2)
   begin : g_chk
      $error("page count, page size and otp size must be powers of two");
   end

   function automatic logic [AW-1:0] page_base(input logic [AW-1:0] a);
      page_base = {a[AW-1:BW], {BW{1'b0}}};
   endfunction : page_base

   // pin synchronisers and edge detection
   logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, mosi_s3;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {mosi_s1, mosi_s2, mosi_s3} <= 3'h0;
      end
      else
      begin
         {cs_s1, cs_s2, cs_s3} <= {cs_n_pin, cs_s1, cs_s2};
         {sck_s1, sck_s2, sck_s3} <= {sck_pin, sck_s1, sck_s2};
         {mosi_s1, mosi_s2, mosi_s3} <= {mosi_pin, mosi_s1, mosi_s2};
      end
   end
   logic sel, cs_fall, cs_rise, sck_rise, sck_fall;
   assign sel = !cs_s2 && !cs_s3;
   assign cs_fall = !cs_s2 && cs_s3;
   assign cs_rise = cs_s2 && !cs_s3;
   assign sck_rise = sel && sck_s2 && !sck_s3; // RULE_01
   assign sck_fall = sel && !sck_s2 && sck_s3; // RULE_01

   // mode capture at select
   logic mode3_q, seen_rise_q, fall_ok;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         mode3_q <= 1'b0;
         seen_rise_q <= 1'b0;
      end
      else if (cs_fall)
      begin
         mode3_q <= sck_s2; // RULE_04
         seen_rise_q <= 1'b0;
      end
      else if (sck_rise)
         seen_rise_q <= 1'b1;
   end
   // in mode 3 the idle-high clock falls once before the first bit
   assign fall_ok = sck_fall && (!mode3_q || seen_rise_q); // RULE_04

   // receive shifter
   logic [6:0] rx_q;
   logic [2:0] bcnt_q;
   logic byte_done;
   logic [7:0] rx_byte;
   assign rx_byte = {rx_q, mosi_s3}; // RULE_18 RULE_01
   assign byte_done = sck_rise && bcnt_q == 3'h7;
   always_ff @(posedge clk)
   begin
      if (!rstn || cs_s2)
      begin
         rx_q <= '0;
         bcnt_q <= '0;
      end
      else if (sck_rise)
      begin
         rx_q <= rx_byte[6:0];
         bcnt_q <= bcnt_q + 3'h1;
      end
   end

   // command sequencer
   sffcp_state_t state_q;
   logic [7:0] op_q;
   logic [23:0] addr_q;
   logic [2:0] cnt_q;
   logic xfer_ok_q;
   logic [BW-1:0] wptr_q;
   logic [AW-1:0] rd_q;
   logic is_read, is_xfer, is_prog;
   assign is_read = op_q == OP_PAGE_READ || op_q == OP_ARRAY_READ;
   assign is_xfer = op_q == OP_XFER_BUF1 || op_q == OP_XFER_BUF2;
   assign is_prog = op_q == OP_PROG_BUF1 || op_q == OP_PROG_BUF2;
   always_ff @(posedge clk)
   begin
      if (!rstn || cs_s2)
      begin
         state_q <= ST_CMD; // RULE_18
         op_q <= '0;
         addr_q <= '0;
         cnt_q <= '0;
         xfer_ok_q <= 1'b0;
         wptr_q <= '0;
      end
      else if (byte_done)
      begin
         case (state_q)
            ST_CMD:
            begin
               op_q <= rx_byte;
               cnt_q <= '0;
               if (rx_byte == OP_ID_READ || rx_byte == OP_STATUS_READ)
                  state_q <= ST_DOUT; // RULE_11
               else if (rx_byte == OP_OTP_PROG)
                  state_q <= ST_DIN;
               else if (rx_byte == OP_PAGE_READ || rx_byte == OP_ARRAY_READ
                  || rx_byte == OP_XFER_BUF1 || rx_byte == OP_XFER_BUF2
                  || rx_byte == OP_PROG_BUF1 || rx_byte == OP_PROG_BUF2)
                  state_q <= ST_ADDR;
               else
                  state_q <= ST_IGNORE;
            end
            ST_ADDR:
            begin
               addr_q <= {addr_q[15:0], rx_byte};
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'(ADDR_BYTES - 1))
               begin
                  cnt_q <= '0;
                  wptr_q <= rx_byte[BW-1:0];
                  if (is_read)
                     state_q <= ST_DUMMY;
                  else if (is_prog)
                     state_q <= ST_DIN;
                  else
                  begin
                     xfer_ok_q <= 1'b1;
                     state_q <= ST_IGNORE;
                  end
               end
            end
            ST_DUMMY:
            begin
               cnt_q <= cnt_q + 3'h1;
               if (cnt_q == 3'(DUMMY_BYTES - 1))
                  state_q <= ST_DOUT;
            end
            ST_DIN:
               wptr_q <= wptr_q + 1'b1;
            default:
               state_q <= state_q;
         endcase
      end
   end

   // busy timer; timed commands during busy are dropped
   logic [31:0] busy_cnt_q;
   logic do_xfer, do_prog, do_otp;
   assign do_xfer = cs_rise && !busy_q && xfer_ok_q; // RULE_12
   assign do_prog = cs_rise && !busy_q && state_q == ST_DIN && is_prog; // RULE_18
   assign do_otp = cs_rise && !busy_q && state_q == ST_DIN && op_q == OP_OTP_PROG;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         busy_cnt_q <= '0;
         busy_q <= 1'b0;
      end
      else if (do_prog)
      begin
         busy_cnt_q <= 32'(EP_CYC); // RULE_07
         busy_q <= 1'b1;
      end
      else if (do_otp)
      begin
         busy_cnt_q <= 32'(OTPP_CYC); // RULE_08
         busy_q <= 1'b1;
      end
      else if (do_xfer)
      begin
         busy_cnt_q <= 32'(XFR_CYC); // RULE_17
         busy_q <= 1'b1;
      end
      else if (busy_cnt_q != '0)
      begin
         busy_cnt_q <= busy_cnt_q - 32'h1;
         busy_q <= busy_cnt_q != 32'h1;
      end
   end

   // storage: array, two buffers, security area
   logic [7:0] mem_q [PAGES * PAGE_BYTES];
   logic [7:0] buf_q [2][PAGE_BYTES];
   logic [7:0] otp_q [OTP_BYTES];
   logic [AW-1:0] tgt;
   logic bsel;
   logic din_we;
   assign tgt = page_base(addr_q[AW-1:0]);
   assign bsel = op_q[1];
   assign din_we = byte_done && state_q == ST_DIN;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < OTP_BYTES; i++)
            otp_q[i] <= IDLE_BYTE;
      end
      else if (din_we && op_q == OP_OTP_PROG && !busy_q)
         otp_q[wptr_q[OW-1:0]] <= rx_byte;
   end
   always_ff @(posedge clk)
   begin
      if (din_we && is_prog)
         buf_q[bsel][wptr_q] <= rx_byte; // RULE_13
      else if (do_xfer)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
            buf_q[bsel][i] <= mem_q[tgt + AW'(i)]; // RULE_12
      end
      if (do_prog)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
            mem_q[tgt + AW'(i)] <= buf_q[bsel][i]; // RULE_07
      end
   end

   // read fetch into the fifo
   logic push_rdy, pop_v;
   logic [7:0] push_data, pop_data;
   logic fetch, tx_load;
   assign fetch = state_q == ST_DOUT && !cs_s2;
   always_comb
   begin
      push_data = 8'h00;
      if (op_q == OP_STATUS_READ)
         push_data = {!busy_q, STATUS_LOW};
      else if (op_q == OP_ID_READ)
      begin
         if (rd_q == '0)
            push_data = MFR_ID; // RULE_11
         else if (rd_q == AW'(1))
            push_data = DEV_ID[15:8];
         else if (rd_q == AW'(2))
            push_data = DEV_ID[7:0];
      end
      else
         push_data = mem_q[rd_q];
   end
   always_ff @(posedge clk)
   begin
      if (!rstn || state_q != ST_DOUT)
         rd_q <= (op_q == OP_ID_READ) ? '0 : addr_q[AW-1:0];
      else if (fetch && push_rdy)
      begin
         if (op_q == OP_PAGE_READ)
            rd_q <= {rd_q[AW-1:BW], rd_q[BW-1:0] + BW'(1)}; // RULE_09
         else if (op_q == OP_ARRAY_READ || rd_q < AW'(3))
            rd_q <= rd_q + AW'(1); // RULE_10
      end
   end

   sffcp_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .flush(cs_s2),
      .in_valid(fetch),
      .in_ready(push_rdy),
      .in_data(push_data),
      .out_valid(pop_v),
      .out_ready(tx_load),
      .out_data(pop_data)
   );

   // transmit shifter, launches on falling edges
   logic [6:0] tx_q;
   logic [2:0] tcnt_q;
   logic [7:0] tx_byte;
   assign tx_load = fall_ok && state_q == ST_DOUT && tcnt_q == 3'h0;
   assign tx_byte = pop_v ? pop_data : IDLE_BYTE;
   always_ff @(posedge clk)
   begin
      if (!rstn || cs_s2)
      begin
         tx_q <= '0;
         tcnt_q <= '0;
         miso_q <= 1'b1;
      end
      else if (fall_ok && state_q == ST_DOUT)
      begin
         tcnt_q <= tcnt_q + 3'h1;
         if (tx_load)
         begin
            miso_q <= tx_byte[7]; // RULE_18
            tx_q <= tx_byte[6:0];
         end
         else
         begin
            miso_q <= tx_q[6]; // RULE_01 RULE_06
            tx_q <= {tx_q[5:0], 1'b0};
         end
      end
   end
   // drive only while selected in the output phase
   always_ff @(posedge clk)
   begin
      if (!rstn)
         miso_oe_n_q <= 1'b1;
      else
         miso_oe_n_q <= !(state_q == ST_DOUT && !cs_s2); // RULE_05
   end
endmodule : sffcp_dev

// File: sffcp_fifo.sv
// byte fifo between the read fetch and the serial shifter
`timescale 1ns/1ps
module sffcp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_chk
      $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wp_q;
   logic [PW:0] rp_q;
   logic push;
   logic pop;
   assign in_ready = (wp_q[PW] == rp_q[PW]) || (wp_q[PW-1:0] != rp_q[PW-1:0]);
   assign out_valid = wp_q != rp_q;
   assign out_data = mem_q[rp_q[PW-1:0]];
   assign push = in_valid && in_ready && !flush;
   assign pop = out_valid && out_ready && !flush;
   always_ff @(posedge clk)
   begin
      if (!rstn || flush)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
      end
   end
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wp_q[PW-1:0]] <= in_data;
   end
endmodule : sffcp_fifo

// File: sffcp_host.sv
// host controller model driving the serial link
`timescale 1ns/1ps
module sffcp_host (
   input wire logic clk,
   output logic cs_n_pin,
   output logic sck_pin,
   output logic mosi_pin,
   input wire logic miso_q,
   input wire logic miso_oe_n_q
);
   logic mode3;
   logic [7:0] rx;
   // miso line has a pull-up
   wire logic miso_w = miso_oe_n_q ? 1'b1 : miso_q;
   initial
   begin
      cs_n_pin = 1'b1;
      sck_pin = 1'b0;
      mosi_pin = 1'b0;
      mode3 = 1'b0;
      rx = 8'h00;
   end
   task automatic sel(input logic m3);
      mode3 = m3;
      sck_pin <= m3;
      repeat (4) @(posedge clk);
      cs_n_pin <= 1'b0;
      repeat (4) @(posedge clk);
      sck_pin <= 1'b0;
   endtask : sel
   // one byte, 80 ns per bit, msb first
   task automatic xb(input logic [7:0] tx);
      mosi_pin <= tx[7];
      for (int i = 7; i >= 0; i--)
      begin
         repeat (4) @(posedge clk);
         sck_pin <= 1'b1;
         if (i > 0)
            mosi_pin <= tx[i - 1];
         repeat (4) @(posedge clk);
         sck_pin <= 1'b0;
         rx = {rx[6:0], miso_w};
      end
   endtask : xb
   task automatic desel;
      repeat (4) @(posedge clk);
      sck_pin <= mode3;
      repeat (4) @(posedge clk);
      cs_n_pin <= 1'b1;
      mosi_pin <= ~mosi_pin;
      @(posedge clk);
   endtask : desel
endmodule : sffcp_host

// File: sffcp_pkg.sv
// constants for the serial flash full-cycle port
package sffcp_pkg;
   localparam logic [7:0] OP_PAGE_READ = 8'hd2;
   localparam logic [7:0] OP_ARRAY_READ = 8'he8;
   localparam logic [7:0] OP_ID_READ = 8'h9f;
   localparam logic [7:0] OP_STATUS_READ = 8'hd7;
   localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
   localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
   localparam logic [7:0] OP_PROG_BUF1 = 8'h82;
   localparam logic [7:0] OP_PROG_BUF2 = 8'h85;
   localparam logic [7:0] OP_OTP_PROG = 8'h9b;
   localparam logic [7:0] IDLE_BYTE = 8'hff;
   localparam logic [6:0] STATUS_LOW = 7'h00;
   localparam int ADDR_BYTES = 3;
   localparam int DUMMY_BYTES = 4;
   localparam int CLK_MHZ = 100;
   // longest times, rounded down to whole cycles
   localparam int T_EP_MS = 25;
   localparam int T_OTPP_US = 500;
   localparam int T_XFR_US = 200;
   localparam int T_EP_CYC = T_EP_MS * 1000 * CLK_MHZ;
   localparam int T_OTPP_CYC = T_OTPP_US * CLK_MHZ;
   localparam int T_XFR_CYC = T_XFR_US * CLK_MHZ;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_WIDTH = 8;
   typedef enum logic [2:0]
   {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DIN = 3'b011,
      ST_DOUT = 3'b100,
      ST_IGNORE = 3'b101
   } sffcp_state_t;
endpackage : sffcp_pkg

// File: sffcp_props.sv
// pin-level assertions for the serial flash port
`timescale 1ns/1ps
module sffcp_props #(
   parameter int EP_CYC = 20,
   parameter int OTPP_CYC = 10,
   parameter int XFR_CYC = 10
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs_n_pin,
   input wire logic sck_pin,
   input wire logic mosi_pin,
   input wire logic miso_q,
   input wire logic miso_oe_n_q,
   input wire logic busy_q
);
   logic sck_q;
   logic [3:0] fall_q;
   logic [3:0] cshi_q;
   logic [31:0] bcnt_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   always_ff @(posedge clk)
   begin
      sck_q <= sck_pin;
   end
   // cycles since the last sck fall
   always_ff @(posedge clk)
   begin
      if (!rstn)
         fall_q <= 4'hf;
      else if (sck_q && !sck_pin)
         fall_q <= 4'h0;
      else if (fall_q != 4'hf)
         fall_q <= fall_q + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (!rstn || !cs_n_pin)
         cshi_q <= 4'h0;
      else if (cshi_q != 4'hf)
         cshi_q <= cshi_q + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (!rstn || !busy_q)
         bcnt_q <= 32'h0;
      else
         bcnt_q <= bcnt_q + 32'h1;
   end
   AST_RST_IDLE: assert property (disable iff (1'b0) !rstn |=> miso_q && miso_oe_n_q && !busy_q)
      else $error("outputs not idle after reset");
   AST_MISO_FALL: assert property (!miso_oe_n_q && $past(!miso_oe_n_q) && $changed(miso_q)
      |-> fall_q inside {[4'd2:4'd5]}) else $error("miso moved away from an sck fall");
   AST_OE_IDLE: assert property (cshi_q > 4'd5 |-> miso_oe_n_q && miso_q)
      else $error("miso driven while deselected");
   AST_OE_RISE: assert property ($rose(cs_n_pin) |-> ##[1:6] miso_oe_n_q)
      else $error("miso not released after deselect");
   AST_OE_SEL: assert property ($fell(miso_oe_n_q) |-> !cs_n_pin && $past(!cs_n_pin, 8))
      else $error("output phase without a command byte");
   AST_BUSY_START: assert property ($rose(busy_q) |-> cs_n_pin && cshi_q inside {[4'd1:4'd8]})
      else $error("busy rose away from a commit");
   AST_BUSY_MAX: assert property (bcnt_q <= EP_CYC)
      else $error("busy longer than the longest operation");
   AST_BUSY_LEN: assert property ($fell(busy_q) |-> bcnt_q == EP_CYC || bcnt_q == OTPP_CYC
      || bcnt_q == XFR_CYC) else $error("busy length matches no operation");
   cover property ($fell(cs_n_pin) && sck_pin);
   cover property ($fell(miso_oe_n_q));
   cover property ($fell(busy_q) && bcnt_q == EP_CYC);
endmodule : sffcp_props
bind sffcp_dev sffcp_props #(.EP_CYC(EP_CYC), .OTPP_CYC(OTPP_CYC), .XFR_CYC(XFR_CYC)) i_props (
   .clk(clk), .rstn(rstn), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .mosi_pin(mosi_pin),
   .miso_q(miso_q), .miso_oe_n_q(miso_oe_n_q), .busy_q(busy_q));
